// ==== dv/mem_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// program memory and stack ram behind the address bus
// ----------------------------------------------------------------
module mem_model #(
  parameter logic [15:0] VRST   = 16'h4000,
  parameter logic [15:0] VBRK   = 16'h4800,
  parameter logic [15:0] VIRQ   = 16'h5000,
  parameter logic [15:0] IRQ_AT = 16'h7FF8
) (
  input  wire logic               i_clk,
  input  wire cpu_regs_pkg::mem_t i_mem,
  output logic [7:0]              o_rdata
);
  import cpu_regs_pkg::*;

  logic [7:0] mem [0:65535];

  // pattern fill, low address byte xor 5A, so an unwritten byte reads as zero only where the low byte is 5A
  initial begin
    for (int a = 0; a < 65536; a++) begin
      mem[a] = a[7:0] ^ 8'h5A;
    end
    {mem[16'h7FFD], mem[16'h7FFC]} = VRST;
    {mem[16'h7FFF], mem[16'h7FFE]} = VBRK;
    {mem[IRQ_AT + 16'h1], mem[IRQ_AT]} = VIRQ;
  end

  // stack page bytes land on the edge that sees the write pulse
  always @(posedge i_clk) begin
    if (i_mem.we) begin
      mem[i_mem.addr] <= i_mem.wdata;
    end
  end

  // answers in the same cycle, no wait states
  assign o_rdata = mem[i_mem.addr];
endmodule
`default_nettype wire

// ==== dv/tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import cpu_regs_pkg::*;
  localparam logic [15:0] VRST   = 16'h4000;
  localparam logic [15:0] VBRK   = 16'h4800;
  localparam logic [15:0] VIRQ   = 16'h5000;
  localparam logic [15:0] IRQ_AT = 16'h7FF8;

  logic        I_MCLK, I_NRST, I_IRQ, I_PSEL, I_PENABLE, I_PWRITE;
  logic        O_PREADY, O_PSLVERR, O_BUSY;
  logic [7:0]  I_RDATA, I_PADDR, O_ACC, O_IDX_X, O_IDX_Y, O_SP, O_STATUS;
  logic [15:0] O_PC;
  logic [31:0] I_PWDATA, O_PRDATA;
  cmd_t        I_CMD;
  mem_t        O_MEM;
  int          err_count, total_checks, seed;
  int          cyc = 0;
  int          m_acc, m_x, m_y, m_sp, m_pc, m_st, m_addr, m_wd, m_we;
  bit          aok;

  cpu_regs cpu_regs_i (.I_MCLK(I_MCLK), .I_NRST(I_NRST), .I_CMD(I_CMD), .I_IRQ(I_IRQ),
    .I_IRQ_VEC(IRQ_AT), .I_RDATA(I_RDATA), .I_PSEL(I_PSEL), .I_PENABLE(I_PENABLE),
    .I_PWRITE(I_PWRITE), .I_PADDR(I_PADDR), .I_PWDATA(I_PWDATA), .O_PRDATA(O_PRDATA),
    .O_PREADY(O_PREADY), .O_PSLVERR(O_PSLVERR), .O_MEM(O_MEM), .O_ACC(O_ACC),
    .O_IDX_X(O_IDX_X), .O_IDX_Y(O_IDX_Y), .O_SP(O_SP), .O_PC(O_PC), .O_STATUS(O_STATUS),
    .O_BUSY(O_BUSY));

  mem_model #(.VRST(VRST), .VBRK(VBRK), .VIRQ(VIRQ), .IRQ_AT(IRQ_AT)) mem_model_i (
    .i_clk(I_MCLK), .i_mem(O_MEM), .o_rdata(I_RDATA));

  // ----------------------------------------------------------------
  // clock, watchdog and helpers
  // ----------------------------------------------------------------
  initial begin
    I_MCLK = 1'b0;
    forever #50 I_MCLK = ~I_MCLK;
  end

  // a hung handshake ends the run instead of spinning forever
  always @(posedge I_MCLK) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      err_count++;
      give_verdict();
    end
  end

  task automatic give_verdict();
    if (err_count == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask

  function automatic cmd_t mk(op_t o, dst_t d, logic [15:0] b, logic [7:0] v);
    mk = '0;
    mk.op = o;
    mk.dst = d;
    mk.base = b;
    mk.data = v;
  endfunction

  task automatic cmp_all();
    chk("acc", m_acc, O_ACC);
    chk("x", m_x, O_IDX_X);
    chk("y", m_y, O_IDX_Y);
    chk("sp", m_sp, O_SP);
    chk("pc", m_pc, O_PC);
    chk("status", m_st, O_STATUS);
    chk("busy", 0, O_BUSY);
    chk("we", m_we, O_MEM.we);
    if (aok) chk("addr", m_addr, O_MEM.addr);
    if (m_we != 0) chk("wdata", m_wd, O_MEM.wdata);
  endtask

  // reference model of one command, pure integers
  task automatic apply(cmd_t c);
    int ix;
    ix = c.dst[1] ? m_y : m_x;
    m_we = 0;
    case (c.op)
      OP_FETCH: begin
        m_addr = m_pc;
        aok = 1;
        m_pc = (m_pc + 1) & 16'hFFFF;
      end
      OP_WR: begin
        case (c.dst)
          DST_A: m_acc = c.data;
          DST_X: m_x = c.data;
          DST_Y: m_y = c.data;
          default: m_sp = c.data;
        endcase
        if (c.upd_nz && c.dst != DST_SP) begin
          m_st[P_N] = c.data[7];
          m_st[P_Z] = (c.data == 8'h00);
        end
        if (c.upd_c) m_st[P_C] = c.carry;
        if (c.upd_v) m_st[P_V] = c.ovf;
      end
      OP_PUSH: begin
        m_addr = 16'h0100 | m_sp;
        m_wd = c.data;
        m_we = 1;
        m_sp = (m_sp - 1) & 8'hFF;
      end
      OP_PULL: begin
        m_sp = (m_sp + 1) & 8'hFF;
        m_addr = 16'h0100 | m_sp;
      end
      OP_IDX, OP_POST: m_addr = (c.base + ix) & 16'hFFFF;
      OP_PRE: m_addr = (c.base[7:0] + m_x) & 8'hFF;
      OP_FLAGS: m_st = {c.data[7:6], 1'b1, m_st[4], c.data[3:0]};
      default: ;
    endcase
  endtask

  // drive at the edge, then check what the previous command left
  task automatic step(cmd_t c, logic irq = 1'b0);
    @(posedge I_MCLK);
    I_CMD <= c;
    I_IRQ <= irq;
    #1;
    cmp_all();
    apply(c);
  endtask

  task automatic wait_idle(output int n);
    n = 0;
    do begin
      @(posedge I_MCLK);
      #1;
      n++;
    end while (O_BUSY !== 1'b0);
  endtask

  task automatic apb(logic wr, logic [7:0] a, logic [31:0] wd,
                     output logic [31:0] rd, output logic er);
    @(posedge I_MCLK);
    I_PSEL <= 1'b1;
    I_PENABLE <= 1'b0;
    I_PWRITE <= wr;
    I_PADDR <= a;
    I_PWDATA <= wd;
    @(posedge I_MCLK);
    I_PENABLE <= 1'b1;
    // only the bench watchdog ends a wait for ready
    do begin
      @(posedge I_MCLK);
    end while (O_PREADY !== 1'b1);
    rd = O_PRDATA;
    er = O_PSLVERR;
    I_PSEL <= 1'b0;
    I_PENABLE <= 1'b0;
  endtask

  task automatic rd_all();
    logic [31:0] rd;
    logic        er;
    int          e [6];
    e = '{m_acc, m_x, m_y, m_sp, m_pc, m_st};
    for (int i = 0; i < 6; i++) begin
      apb(1'b0, 8'(4 * i), 32'h0, rd, er);
      chk("prdata", e[i], rd);
      chk("pslverr", 0, er);
    end
  endtask

  // entry pushes counter high, low, then status with the cause bit
  task automatic enter(logic brk);
    int n;
    int s;
    @(posedge I_MCLK);
    if (brk) I_CMD <= mk(OP_BRK, DST_A, 16'h0000, 8'h00);
    else I_IRQ <= 1'b1;
    @(posedge I_MCLK);
    I_CMD <= '0;
    I_IRQ <= 1'b0;
    wait_idle(n);
    s = 16'h0100 | m_sp;
    chk("push_hi", m_pc >> 8, mem_model_i.mem[s]);
    chk("push_lo", m_pc & 8'hFF, mem_model_i.mem[16'h0100 | ((s - 1) & 8'hFF)]);
    m_st = (m_st & 8'hEF) | (brk ? 8'h10 : 8'h00) | 8'h20;
    chk("push_st", m_st, mem_model_i.mem[16'h0100 | ((s - 2) & 8'hFF)]);
    m_st = m_st | 8'h04;
    m_sp = (m_sp - 3) & 8'hFF;
    m_pc = brk ? VBRK : VIRQ;
    m_we = 0;
    aok = 0;
    cmp_all();
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [31:0] rd, r;
    logic        er;
    cmd_t        c;
    int          n;
    seed = 4145;
    I_NRST = 1'b0;
    I_CMD = '0;
    I_IRQ = 1'b0;
    I_PSEL = 1'b0;
    I_PENABLE = 1'b0;
    I_PWRITE = 1'b0;
    I_PADDR = 8'h00;
    I_PWDATA = 32'h0;
    @(posedge I_MCLK);
    #1;
    chk("rst_status", 8'h20, O_STATUS);
    chk("rst_busy", 1, O_BUSY);
    repeat (2) @(posedge I_MCLK);
    I_NRST <= 1'b1;
    wait_idle(n);
    chk("init_edges", 8, n);
    {m_acc, m_x, m_y, m_sp, m_we} = '0;
    m_pc = VRST;
    m_addr = VRST;
    m_st = 8'h24;
    aok = 1'b1;
    cmp_all();
    // software owns the stack pointer start value
    apb(1'b1, OFS_SP, 32'h000000FF, rd, er);
    r = $random(seed);
    apb(1'b1, OFS_IDX_X, {24'h0, r[7:0]}, rd, er);
    apb(1'b1, OFS_STAT, 32'h0000000C, rd, er);
    apb(1'b1, OFS_PC, {16'h0000, VRST + 16'h0010}, rd, er);
    apb(1'b1, OFS_CORE, 32'hFFFFFFFF, rd, er);
    apb(1'b1, 8'h1C, 32'h000000AA, rd, er);
    chk("unmapped_err", 1, er);
    apb(1'b0, OFS_CORE, 32'h0, rd, er);
    chk("core", {28'h0, 1'b0, 3'(ST_RUN)}, rd);
    m_sp = 8'hFF;
    m_x = r[7:0];
    m_st = 8'h2C;
    m_pc = VRST + 16'h0010;
    rd_all();
    for (int i = 0; i < 3; i++) step(mk(OP_FETCH, DST_A, 16'h0000, 8'h00));
    for (int i = 0; i < 16; i++) begin
      r = $random(seed);
      c = mk(OP_WR, dst_t'(i < 2 ? 2'h0 : r[9:8]), 16'h0000, i < 2 ? 8'h00 : r[7:0]);
      {c.carry, c.ovf, c.upd_c, c.upd_v} = r[13:10];
      c.upd_nz = r[14] | (i < 4);
      step(c);
    end
    // pushes cross the bottom of the stack page and wrap
    step(mk(OP_WR, DST_SP, 16'h0000, 8'h02));
    for (int i = 0; i < 4; i++) step(mk(OP_PUSH, DST_A, 16'h0000, 8'(i + 8'hC0)));
    for (int i = 0; i < 4; i++) step(mk(OP_PULL, DST_A, 16'h0000, 8'h00));
    step(mk(OP_IDX, DST_X, 16'h12F0, 8'h00));
    step(mk(OP_IDX, DST_Y, 16'hFFF0, 8'h00));
    step(mk(OP_PRE, DST_X, 16'h00F8, 8'h00));
    step(mk(OP_POST, DST_Y, 16'h3080, 8'h00));
    step(mk(OP_FLAGS, DST_A, 16'h0000, 8'hDF));
    for (int i = 0; i < 3; i++) step('0, 1'b1);
    step(mk(OP_FLAGS, DST_A, 16'h0000, 8'h00));
    step('0);
    enter(1'b0);
    step(mk(OP_FETCH, DST_A, 16'h0000, 8'h00));
    step(mk(OP_FLAGS, DST_A, 16'h0000, 8'h0C));
    step('0);
    enter(1'b1);
    step(mk(OP_FETCH, DST_A, 16'h0000, 8'h00));
    step('0);
    step('0);
    rd_all();
    give_verdict();
  end
endmodule
`default_nettype wire

// ==== src/cpu_regs.sv ====
// Chosen here: the address map and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
module cpu_regs (
  input  wire logic               I_MCLK,
  input  wire logic               I_NRST,
  input  wire cpu_regs_pkg::cmd_t I_CMD,
  input  wire logic               I_IRQ,
  input  wire logic [15:0]        I_IRQ_VEC,
  input  wire logic [7:0]         I_RDATA,
  input  wire logic               I_PSEL,
  input  wire logic               I_PENABLE,
  input  wire logic               I_PWRITE,
  input  wire logic [7:0]         I_PADDR,
  input  wire logic [31:0]        I_PWDATA,
  output logic [31:0]             O_PRDATA,
  output logic                    O_PREADY,
  output logic                    O_PSLVERR,
  output cpu_regs_pkg::mem_t      O_MEM,
  output logic [7:0]              O_ACC,
  output logic [7:0]              O_IDX_X,
  output logic [7:0]              O_IDX_Y,
  output logic [7:0]              O_SP,
  output logic [15:0]             O_PC,
  output logic [7:0]              O_STATUS,
  output logic                    O_BUSY
);
  import cpu_regs_pkg::*;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [15:0] stack_addr(input logic [7:0] sp);
    stack_addr = {STACK_PAGE, sp};
  endfunction

  function automatic logic [15:0] index_add(input logic [15:0] base, input logic [7:0] idx);
    index_add = base + {8'h00, idx};
  endfunction

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  state_t      st_r, st_nxt;
  logic [2:0]  cnt_r, cnt_nxt;
  logic [7:0]  acc_r, acc_nxt, x_r, x_nxt, y_r, y_nxt, sp_r, sp_nxt;
  logic [15:0] pc_r, pc_nxt, vec_r, vec_nxt;
  logic [7:0]  p_r, p_nxt, vlo_r, vlo_nxt;
  logic        brk_r, brk_nxt, rst_ent_r, rst_ent_nxt, busy_r, busy_nxt;
  mem_t        mem_r, mem_nxt;
  logic        pready_r, pready_nxt, pslverr_r, pslverr_nxt;
  logic [31:0] prdata_r, prdata_nxt;
  logic        apb_wr, take_int, run_cmd;
  logic [7:0]  idx_sel;

  // apb write lands only at the completing edge
  assign apb_wr   = I_PSEL & I_PENABLE & I_PWRITE & pready_r;
  assign run_cmd  = (st_r == ST_RUN);
  // mask only gates the external request; break is taken in ST_RUN whatever the mask
  assign take_int = run_cmd & ((I_IRQ & ~p_r[P_I] & (I_CMD.op == OP_NONE))
                    | (I_CMD.op == OP_BRK));
  assign idx_sel  = I_CMD.dst[1] ? y_r : x_r;

  // ----------------------------------------------------------------
  // core sequencing and register updates
  // ----------------------------------------------------------------
  always_comb begin
    st_nxt      = st_r;
    cnt_nxt     = cnt_r;
    acc_nxt     = acc_r;
    x_nxt       = x_r;
    y_nxt       = y_r;
    sp_nxt      = sp_r;
    pc_nxt      = pc_r;
    p_nxt       = p_r;
    vec_nxt     = vec_r;
    vlo_nxt     = vlo_r;
    brk_nxt     = brk_r;
    rst_ent_nxt = rst_ent_r;
    mem_nxt     = mem_r;
    mem_nxt.we  = 1'b0;
    case (st_r)
      ST_INIT: begin
        // fixed settling time before the vector is read
        if (cnt_r == INIT_LAST) begin
          st_nxt       = ST_VLO;
          mem_nxt.addr = VEC_RESET;
        end else begin
          cnt_nxt = cnt_r + 3'h1;
        end
      end
      ST_VLO: begin
        vlo_nxt      = I_RDATA;
        mem_nxt.addr = mem_r.addr + 16'h0001;
        st_nxt       = ST_VHI;
      end
      ST_VHI: begin
        pc_nxt       = {I_RDATA, vlo_r};
        p_nxt[P_I]   = 1'b1;
        if (rst_ent_r) begin
          p_nxt[P_D] = 1'b0;
        end
        rst_ent_nxt  = 1'b0;
        mem_nxt.addr = {I_RDATA, vlo_r};
        st_nxt       = ST_RUN;
      end
      ST_RUN: begin
        if (take_int) begin
          // entry pushes high, low, then status
          brk_nxt       = (I_CMD.op == OP_BRK);
          vec_nxt       = (I_CMD.op == OP_BRK) ? VEC_BRK : I_IRQ_VEC;
          mem_nxt.addr  = stack_addr(sp_r);
          mem_nxt.wdata = pc_r[15:8];
          mem_nxt.we    = 1'b1;
          sp_nxt        = sp_r - 8'h01;
          st_nxt        = ST_PSH_L;
        end else begin
          case (I_CMD.op)
            OP_FETCH: begin
              mem_nxt.addr = pc_r;
              pc_nxt       = pc_r + 16'h0001;
            end
            OP_WR: begin
              case (I_CMD.dst)
                DST_A:   acc_nxt = I_CMD.data;
                DST_X:   x_nxt   = I_CMD.data;
                DST_Y:   y_nxt   = I_CMD.data;
                default: sp_nxt  = I_CMD.data;
              endcase
              // stack pointer moves leave N and Z alone; carry and overflow still follow upd_c and upd_v
              if (I_CMD.upd_nz && I_CMD.dst != DST_SP) begin
                p_nxt[P_N] = I_CMD.data[7];
                p_nxt[P_Z] = (I_CMD.data == 8'h00);
              end
              if (I_CMD.upd_c) begin
                p_nxt[P_C] = I_CMD.carry;
              end
              if (I_CMD.upd_v) begin
                p_nxt[P_V] = I_CMD.ovf;
              end
            end
            OP_FLAGS: begin
              // break flag is kept here; only interrupt entry or an apb status write changes it
              p_nxt = {I_CMD.data[7:6], 1'b1, p_r[P_B], I_CMD.data[3:0]};
            end
            OP_PUSH: begin
              mem_nxt.addr  = stack_addr(sp_r);
              mem_nxt.wdata = I_CMD.data;
              mem_nxt.we    = 1'b1;
              sp_nxt        = sp_r - 8'h01;
            end
            OP_PULL: begin
              sp_nxt       = sp_r + 8'h01;
              mem_nxt.addr = stack_addr(sp_r + 8'h01);
            end
            OP_IDX: begin
              mem_nxt.addr = index_add(I_CMD.base, idx_sel);
            end
            OP_PRE: begin
              // pointer stays in page zero, carry dropped
              mem_nxt.addr = {8'h00, I_CMD.base[7:0] + x_r};
            end
            OP_POST: begin
              mem_nxt.addr = index_add(I_CMD.base, y_r);
            end
            default: begin
              mem_nxt.we = 1'b0;
            end
          endcase
        end
      end
      ST_PSH_L: begin
        mem_nxt.addr  = stack_addr(sp_r);
        mem_nxt.wdata = pc_r[7:0];
        mem_nxt.we    = 1'b1;
        sp_nxt        = sp_r - 8'h01;
        st_nxt        = ST_PSH_P;
      end
      ST_PSH_P: begin
        // pushed copy carries the entry cause, then mask is set
        mem_nxt.addr  = stack_addr(sp_r);
        mem_nxt.wdata = {p_r[7:5], brk_r, p_r[3:0]};
        mem_nxt.we    = 1'b1;
        sp_nxt        = sp_r - 8'h01;
        p_nxt[P_B]    = brk_r;
        p_nxt[P_I]    = 1'b1;
        st_nxt        = ST_VEC;
      end
      ST_VEC: begin
        // vector goes out only after the status write has left the bus
        mem_nxt.addr = vec_r;
        st_nxt       = ST_VLO;
      end
      default: begin
        st_nxt = ST_INIT;
      end
    endcase
    // software access wins over the core in the same cycle
    if (apb_wr) begin
      case (I_PADDR)
        OFS_ACC:   acc_nxt = I_PWDATA[7:0];
        OFS_IDX_X: x_nxt   = I_PWDATA[7:0];
        OFS_IDX_Y: y_nxt   = I_PWDATA[7:0];
        OFS_SP:    sp_nxt  = I_PWDATA[7:0];
        OFS_PC:    pc_nxt  = I_PWDATA[15:0];
        OFS_STAT:  p_nxt   = I_PWDATA[7:0];
        default:   p_nxt   = p_nxt;
      endcase
    end
    p_nxt[P_ONE] = 1'b1;
    busy_nxt     = (st_nxt != ST_RUN);
  end

  // held in reset while the pin is low
  always_ff @(posedge I_MCLK or negedge I_NRST) begin
    if (!I_NRST) begin
      st_r      <= ST_INIT;
      cnt_r     <= 3'h0;
      acc_r     <= ACC_RST;
      x_r       <= ACC_RST;
      y_r       <= ACC_RST;
      sp_r      <= SP_RST;
      pc_r      <= PC_RST;
      p_r       <= P_RST;
      vec_r     <= VEC_RESET;
      vlo_r     <= 8'h00;
      brk_r     <= 1'b0;
      rst_ent_r <= 1'b1;
      busy_r    <= 1'b1;
      mem_r     <= '0;
    end else begin
      st_r      <= st_nxt;
      cnt_r     <= cnt_nxt;
      acc_r     <= acc_nxt;
      x_r       <= x_nxt;
      y_r       <= y_nxt;
      sp_r      <= sp_nxt;
      pc_r      <= pc_nxt;
      p_r       <= p_nxt;
      vec_r     <= vec_nxt;
      vlo_r     <= vlo_nxt;
      brk_r     <= brk_nxt;
      rst_ent_r <= rst_ent_nxt;
      busy_r    <= busy_nxt;
      mem_r     <= mem_nxt;
    end
  end

  // ----------------------------------------------------------------
  // apb slave: one wait state, reads sampled in the first access cycle
  // ----------------------------------------------------------------
  always_comb begin
    pready_nxt  = I_PSEL & I_PENABLE & ~pready_r;
    prdata_nxt  = prdata_r;
    pslverr_nxt = 1'b0;
    if (I_PSEL && I_PENABLE && !pready_r) begin
      prdata_nxt = 32'h0000_0000;
      case (I_PADDR)
        OFS_ACC:   prdata_nxt = {24'h00_0000, acc_r};
        OFS_IDX_X: prdata_nxt = {24'h00_0000, x_r};
        OFS_IDX_Y: prdata_nxt = {24'h00_0000, y_r};
        OFS_SP:    prdata_nxt = {24'h00_0000, sp_r};
        OFS_PC:    prdata_nxt = {16'h0000, pc_r};
        OFS_STAT:  prdata_nxt = {24'h00_0000, p_r};
        OFS_CORE:  prdata_nxt = {28'h000_0000, busy_r, st_r};
        default:   pslverr_nxt = 1'b1;
      endcase
    end
  end

  always_ff @(posedge I_MCLK or negedge I_NRST) begin
    if (!I_NRST) begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= 32'h0000_0000;
    end else begin
      pready_r  <= pready_nxt;
      pslverr_r <= pslverr_nxt;
      prdata_r  <= prdata_nxt;
    end
  end

  // outputs are the registers themselves
  assign O_PRDATA  = prdata_r;
  assign O_PREADY  = pready_r;
  assign O_PSLVERR = pslverr_r;
  assign O_MEM     = mem_r;
  assign O_ACC     = acc_r;
  assign O_IDX_X   = x_r;
  assign O_IDX_Y   = y_r;
  assign O_SP      = sp_r;
  assign O_PC      = pc_r;
  assign O_STATUS  = p_r;
  assign O_BUSY    = busy_r;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  logic [3:0] init_len_r;

  // cycles spent in the init state since release
  always_ff @(posedge I_MCLK or negedge I_NRST) begin
    if (!I_NRST) begin
      init_len_r <= 4'h0;
    end else if (st_r == ST_INIT) begin
      init_len_r <= init_len_r + 4'h1;
    end
  end

  default clocking cb @(posedge I_MCLK); endclocking
  default disable iff (!I_NRST);

  a_init_len: assert property (
    (st_r == ST_VLO && $past(st_r) == ST_INIT) |-> init_len_r == INIT_CYCLES)
    else $error("init sequence length wrong");
  a_vec_load: assert property (
    (st_r == ST_VHI && rst_ent_r && !apb_wr)
    |=> pc_r == {$past(I_RDATA), vlo_r} && p_r[P_I] && !p_r[P_D])
    else $error("reset vector load wrong");
  a_fetch_step: assert property (
    (run_cmd && !take_int && I_CMD.op == OP_FETCH && !apb_wr)
    |=> pc_r == $past(pc_r) + 16'h0001 && O_MEM.addr == $past(pc_r))
    else $error("fetch did not advance counter");
  a_push_stack: assert property (
    (run_cmd && !take_int && I_CMD.op == OP_PUSH && !apb_wr)
    |=> sp_r == $past(sp_r) - 8'h01 && O_MEM.we && O_MEM.addr == {8'h01, $past(sp_r)})
    else $error("push stack update wrong");
  a_pull_stack: assert property (
    (run_cmd && !take_int && I_CMD.op == OP_PULL && !apb_wr)
    |=> sp_r == $past(sp_r) + 8'h01 && O_MEM.addr[15:8] == 8'h01 && !O_MEM.we)
    else $error("pull stack update wrong");
  a_index_ea: assert property (
    (run_cmd && !take_int && I_CMD.op == OP_IDX)
    |=> O_MEM.addr == $past(I_CMD.base) + {8'h00, $past(idx_sel)})
    else $error("indexed address wrong");
  a_int_entry: assert property (
    (take_int && !apb_wr) |=> st_r == ST_PSH_L && O_MEM.we
    ##1 st_r == ST_PSH_P && O_MEM.we
    ##1 st_r == ST_VEC && O_MEM.we && p_r[P_I] && p_r[P_B] == brk_r)
    else $error("interrupt entry sequence wrong");
  a_zero_flag: assert property (
    (run_cmd && !take_int && I_CMD.op == OP_WR && I_CMD.upd_nz
     && I_CMD.dst != DST_SP && !apb_wr)
    |=> p_r[P_Z] == ($past(I_CMD.data) == 8'h00) && p_r[P_N] == $past(I_CMD.data[7]))
    else $error("zero or sign flag wrong");
  a_irq_masked: assert property (
    (run_cmd && p_r[P_I] && I_IRQ && I_CMD.op == OP_NONE) |=> st_r == ST_RUN)
    else $error("masked interrupt taken");
  a_bit5_one: assert property (p_r[P_ONE])
    else $error("status bit five not one");
  a_apb_ready: assert property (
    (I_PSEL && I_PENABLE && !pready_r) |=> pready_r)
    else $error("apb ready late");

endmodule
`default_nettype wire

// ==== src/cpu_regs_pkg.sv ====
package cpu_regs_pkg;

  // ----------------------------------------------------------------
  // register offsets on the apb slave (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_ACC   = 8'h00;
  localparam logic [7:0] OFS_IDX_X = 8'h04;
  localparam logic [7:0] OFS_IDX_Y = 8'h08;
  localparam logic [7:0] OFS_SP    = 8'h0C;
  localparam logic [7:0] OFS_PC    = 8'h10;
  localparam logic [7:0] OFS_STAT  = 8'h14;
  localparam logic [7:0] OFS_CORE  = 8'h18;

  // ----------------------------------------------------------------
  // status bit positions
  // ----------------------------------------------------------------
  localparam int P_C   = 0;
  localparam int P_Z   = 1;
  localparam int P_I   = 2;
  localparam int P_D   = 3;
  localparam int P_B   = 4;
  localparam int P_ONE = 5;
  localparam int P_V   = 6;
  localparam int P_N   = 7;

  // ----------------------------------------------------------------
  // reset values, vectors and counts
  // ----------------------------------------------------------------
  localparam logic [7:0]  ACC_RST     = 8'h00;
  localparam logic [7:0]  SP_RST      = 8'h00;
  localparam logic [7:0]  P_RST       = 8'h20;
  localparam logic [15:0] PC_RST      = 16'h0000;
  localparam logic [7:0]  STACK_PAGE  = 8'h01;
  localparam logic [15:0] VEC_RESET   = 16'h7FFC;
  localparam logic [15:0] VEC_BRK     = 16'h7FFE;
  localparam logic [2:0]  INIT_LAST   = 3'h5;
  localparam logic [3:0]  INIT_CYCLES = 4'h6;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    OP_NONE  = 4'h0,
    OP_FETCH = 4'h1,
    OP_WR    = 4'h2,
    OP_PUSH  = 4'h3,
    OP_PULL  = 4'h4,
    OP_IDX   = 4'h5,
    OP_PRE   = 4'h6,
    OP_POST  = 4'h7,
    OP_BRK   = 4'h8,
    OP_FLAGS = 4'h9
  } op_t;

  typedef enum logic [1:0] {
    DST_A  = 2'h0,
    DST_X  = 2'h1,
    DST_Y  = 2'h2,
    DST_SP = 2'h3
  } dst_t;

  typedef enum logic [2:0] {
    ST_INIT  = 3'h0,
    ST_VLO   = 3'h1,
    ST_VHI   = 3'h3,
    ST_RUN   = 3'h2,
    ST_PSH_L = 3'h6,
    ST_PSH_P = 3'h7,
    ST_VEC   = 3'h5
  } state_t;

  typedef struct packed {
    op_t         op;
    dst_t        dst;
    logic [15:0] base;
    logic [7:0]  data;
    logic        carry;
    logic        ovf;
    logic        upd_nz;
    logic        upd_c;
    logic        upd_v;
  } cmd_t;

  typedef struct packed {
    logic [15:0] addr;
    logic [7:0]  wdata;
    logic        we;
  } mem_t;

endpackage
